// ==== dv/cpu_core_model.sv ====
// Behavioural CPU core that takes, runs and finishes interrupts
`timescale 1ns/100ps
module cpu_core_model (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // From the controller
   input wire logic int_req_in,
   input wire logic [3:0] int_level_in,
   input wire logic [3:0] cpu_level_in,
   // To the controller
   output logic int_ack_out,
   output logic handler_done_out,
   output logic ipl_load_out,
   output logic [3:0] ipl_value_out
);
   logic [3:0] saved_r;
   logic [3:0] cnt_r;
   logic busy_r;
   // Ack after a short delay, restore old level when the handler ends
   always_ff @(posedge core_clk_in) begin
      int_ack_out <= 1'b0;
      handler_done_out <= 1'b0;
      ipl_load_out <= 1'b0;
      if (reset_in) begin
         busy_r <= 1'b0;
         cnt_r <= 4'h0;
         saved_r <= 4'h0;
         ipl_value_out <= 4'h0;
      end else if (!busy_r && int_req_in) begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == 4'h3) begin
            int_ack_out <= 1'b1;
            ipl_load_out <= 1'b1;
            ipl_value_out <= int_level_in;
            saved_r <= cpu_level_in;
            busy_r <= 1'b1;
            cnt_r <= 4'h0;
         end
      end else if (busy_r) begin
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == 4'h5) begin
            handler_done_out <= 1'b1;
            ipl_load_out <= 1'b1;
            ipl_value_out <= saved_r;
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
         end
      end
   end
endmodule

// ==== dv/vectored_priority_interrupt_controller_test.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module vectored_priority_interrupt_controller_test;
   import intc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0, ival, lvl, cpl;
   logic [1:0] bresp, rresp, rs, wresp;
   logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, ack, done, load, req;
   src_vec_t src = '0;
   logic [4:0] pin = 5'h00, trap = 5'h00;
   logic [6:0] vec;
   logic [23:0] addr;
   logic [15:0] rv;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   // Clock and cycle ceiling
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         print_verdict();
      end
   end
   vectored_priority_interrupt_controller i_vectored_priority_interrupt_controller (.core_clk_in(clk),
      .reset_in(rst), .s_awaddr_in(awaddr), .s_awvalid_in(aw_v), .s_awready_out(aw_rdy), .s_wdata_in(wdata),
      .s_wstrb_in(wstrb), .s_wvalid_in(w_v), .s_wready_out(w_rdy), .s_bresp_out(bresp), .s_bvalid_out(b_v),
      .s_bready_in(b_r), .s_araddr_in(araddr), .s_arvalid_in(ar_v), .s_arready_out(ar_rdy),
      .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(r_v), .s_rready_in(r_r), .src_req_in(src),
      .ext_pin_in(pin), .trap_in(trap), .int_ack_in(ack), .handler_done_in(done), .ipl_load_in(load),
      .ipl_value_in(ival), .int_req_out(req), .int_vector_out(vec), .int_level_out(lvl),
      .int_addr_out(addr), .cpu_priority_level_out(cpl));
   cpu_core_model i_cpu_core_model (.core_clk_in(clk), .reset_in(rst), .int_req_in(req), .int_level_in(lvl),
      .cpu_level_in(cpl), .int_ack_out(ack), .handler_done_out(done), .ipl_load_out(load), .ipl_value_out(ival));
   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Bus write: hold each channel until its ready, bready until bvalid
   task automatic wr(input logic [5:0] i, input logic [15:0] d);
      logic a, w, f;
      @(posedge clk);
      awaddr <= {i, 2'b00};
      wdata <= {16'h0000, d};
      wstrb <= 4'h3;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      do begin
         @(negedge clk);
         a = aw_rdy;
         w = w_rdy;
         f = b_v;
         wresp = bresp;
         @(posedge clk);
         if (a) aw_v <= 1'b0;
         if (w) w_v <= 1'b0;
         if (f) b_r <= 1'b0;
      end while (!f);
   endtask
   // Bus read with response code
   task automatic rd(input logic [5:0] i, output logic [15:0] d, output logic [1:0] r);
      logic a, f;
      @(posedge clk);
      araddr <= {i, 2'b00};
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
         @(negedge clk);
         a = ar_rdy;
         f = r_v;
         d = rdata[15:0];
         r = rresp;
         @(posedge clk);
         if (a) ar_v <= 1'b0;
         if (f) r_r <= 1'b0;
      end while (!f);
   endtask
   task automatic rc(input string n, input logic [5:0] i, input logic [15:0] e);
      rd(i, rv, rs);
      chk(n, e, rv);
   endtask
   task automatic pulse(input src_vec_t s, input logic [4:0] t);
      @(posedge clk);
      src <= s;
      trap <= t;
      @(posedge clk);
      src <= '0;
      trap <= 5'h00;
   endtask
   // Wait for a request, looking only between edges
   task automatic wreq();
      @(negedge clk);
      for (int k = 0; k < 40 && req !== 1'b1; k++) @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rc("ctl1 reset", IDX_CTL1, 16'h0000);
      rd(6'h21, rv, rs);
      chk("unmapped resp", 2'b10, rs);
      wr(6'h21, 16'hffff);
      chk("unmapped wresp", 2'b10, wresp);
      wr(IDX_CORE, 16'h0008);
      rc("top bit", IDX_CORE, 16'h0000);
      wr(IDX_CTL1, 16'h8000);
      wr(IDX_SR, 16'h00e0);
      rc("sr frozen", IDX_SR, 16'h0000);
      wr(IDX_CTL1, 16'h0000);
      wr(IDX_EN0, 16'h0008);
      chk("write resp", 2'b00, wresp);
      wr(IDX_PRIO0, 16'h5000);
      pulse(72'h8, 5'h00);
      wreq();
      chk("vector", 7'h0b, vec);
      chk("level", 4'h5, lvl);
      chk("addr", 24'h00001a, addr);
      rc("flags", IDX_FLAG0, 16'h0008);
      rc("vls", IDX_VLS, 16'h050b);
      wr(IDX_FLAG0, 16'h0000);
      repeat (20) @(posedge clk);
      wr(IDX_SR, 16'h00e0);
      pulse(72'h8, 5'h00);
      repeat (20) @(negedge clk);
      chk("blocked", 1'b0, req);
      chk("cpu level", 4'h7, cpl);
      wr(IDX_SR, 16'h0000);
      wreq();
      chk("unblocked", 1'b1, req);
      wr(IDX_FLAG0, 16'h0000);
      repeat (20) @(posedge clk);
      wr(IDX_CTL1, 16'h8000);
      pulse(72'h0, 5'h02);
      wreq();
      chk("trap vector", 7'h02, vec);
      chk("trap addr", 24'h000008, addr);
      rc("trap flag", IDX_CTL1, 16'h8008);
      wr(IDX_CTL1, 16'h0000);
      repeat (20) @(posedge clk);
      wr(IDX_CTL2, 16'h8000);
      wr(IDX_EN0 + 6'h02, 16'h4000);
      wr(IDX_PRIO0 + 6'h0b, 16'h0300);
      pulse(72'h4000_0000_0000, 5'h00);
      wreq();
      chk("alt vector", 7'h36, vec);
      chk("alt addr", 24'h000170, addr);
      wr(IDX_FLAG0 + 6'h02, 16'h0000);
      pulse(72'h18_0000_0000_0000_00, 5'h00);
      rc("unimpl flags", IDX_FLAG0 + 6'h03, 16'h0000);
      @(posedge clk);
      pin <= 5'h01;
      repeat (3) @(posedge clk);
      rc("rise flag", IDX_FLAG0, 16'h0001);
      wr(IDX_CTL2, 16'h8001);
      wr(IDX_FLAG0, 16'h0000);
      pin <= 5'h00;
      repeat (3) @(posedge clk);
      rc("fall flag", IDX_FLAG0, 16'h0001);
      print_verdict();
   end
endmodule

// ==== verilog/axil_reg_slave.sv ====
// AXI4-Lite slave that turns bus transfers into register accesses
`timescale 1ns/100ps
module axil_reg_slave (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // AXI4-Lite
   input wire logic [7:0] s_awaddr_in,
   input wire logic s_awvalid_in,
   output logic s_awready_out,
   input wire logic [31:0] s_wdata_in,
   input wire logic [3:0] s_wstrb_in,
   input wire logic s_wvalid_in,
   output logic s_wready_out,
   output logic [1:0] s_bresp_out,
   output logic s_bvalid_out,
   input wire logic s_bready_in,
   input wire logic [7:0] s_araddr_in,
   input wire logic s_arvalid_in,
   output logic s_arready_out,
   output logic [31:0] s_rdata_out,
   output logic [1:0] s_rresp_out,
   output logic s_rvalid_out,
   input wire logic s_rready_in,
   // Register side
   reg_if.bus rif
);
   import intc_pkg::*;
   logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
   logic [5:0] aw_idx_r;
   logic [15:0] w_data_r;
   logic [1:0] w_strb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   // Handshakes and the merged write request
   wire aw_hs = s_awvalid_in && s_awready_out;
   wire w_hs = s_wvalid_in && s_wready_out;
   wire have_aw = aw_full_r || aw_hs;
   wire have_w = w_full_r || w_hs;
   wire do_write = have_aw && have_w && !bvalid_r;
   wire [5:0] wr_idx = aw_full_r ? aw_idx_r : s_awaddr_in[7:2];
   wire wr_hit = wr_idx <= IDX_LAST;
   wire [5:0] ar_idx = s_araddr_in[7:2];
   wire ar_hs = s_arvalid_in && s_arready_out;
   assign s_awready_out = !aw_full_r && !bvalid_r;
   assign s_wready_out = !w_full_r && !bvalid_r;
   assign s_arready_out = !rvalid_r;
   assign rif.wr_en = do_write && wr_hit;
   assign rif.wr_idx = wr_idx;
   assign rif.wr_data = w_full_r ? w_data_r : s_wdata_in[15:0];
   assign rif.wr_strb = w_full_r ? w_strb_r : s_wstrb_in[1:0];
   assign rif.rd_idx = ar_idx;
   assign s_bvalid_out = bvalid_r;
   assign s_bresp_out = bresp_r;
   assign s_rvalid_out = rvalid_r;
   assign s_rresp_out = rresp_r;
   assign s_rdata_out = rdata_r;
   // Write channel holding and response
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'b00;
         aw_idx_r <= 6'h00;
         w_data_r <= 16'h0000;
         w_strb_r <= 2'b00;
      end else begin
         aw_full_r <= have_aw && !do_write;
         w_full_r <= have_w && !do_write;
         if (aw_hs) aw_idx_r <= s_awaddr_in[7:2];
         if (w_hs) w_data_r <= s_wdata_in[15:0];
         if (w_hs) w_strb_r <= s_wstrb_in[1:0];
         if (do_write) bvalid_r <= 1'b1;
         else if (s_bready_in) bvalid_r <= 1'b0;
         if (do_write) bresp_r <= wr_hit ? 2'b00 : 2'b10;
      end
   end
   // Read channel; unmapped words answer SLVERR with zero data
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         rvalid_r <= 1'b0;
         rresp_r <= 2'b00;
         rdata_r <= 32'h00000000;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rresp_r <= (ar_idx <= IDX_LAST) ? 2'b00 : 2'b10;
         rdata_r <= {16'h0000, rif.rd_data};
      end else if (s_rready_in) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule

// ==== verilog/intc_pkg.sv ====
// Constants and types shared by the interrupt controller files
package intc_pkg;
   localparam int NUM_SRC = 72;
   localparam int NUM_FLAG_REG = 5;
   localparam int NUM_PRIO_REG = 18;
   typedef logic [NUM_SRC-1:0] src_vec_t;
   typedef logic [NUM_SRC-1:0][2:0] prio_arr_t;
   // Vector table geometry
   localparam logic [23:0] VEC_BASE = 24'h000004;
   localparam logic [23:0] ALT_OFFSET = 24'h000100;
   localparam logic [6:0] VEC_USER_OFS = 7'h08;
   localparam logic [6:0] VEC_RSV_FIRST = 7'h50;
   localparam logic [6:0] VEC_RSV_LAST = 7'h7d;
   // Requests with no source behind them (59 and 60) are held at zero
   localparam src_vec_t IMPL_MASK = 72'hffe7ffffffffffffff;
   localparam int EXT_SRC [0:4] = '{0, 20, 29, 53, 54};
   // Register word indices; byte address is four times the index
   localparam logic [5:0] IDX_CTL1 = 6'h00;
   localparam logic [5:0] IDX_CTL2 = 6'h01;
   localparam logic [5:0] IDX_FLAG0 = 6'h02;
   localparam logic [5:0] IDX_EN0 = 6'h07;
   localparam logic [5:0] IDX_PRIO0 = 6'h0c;
   localparam logic [5:0] IDX_VLS = 6'h1e;
   localparam logic [5:0] IDX_SR = 6'h1f;
   localparam logic [5:0] IDX_CORE = 6'h20;
   localparam logic [5:0] IDX_LAST = 6'h20;
   // Field positions and masks
   localparam int NEST_BIT = 15;
   localparam int ALT_BIT = 15;
   localparam int IPL_LSB = 5;
   localparam int TOP_BIT = 3;
   localparam int LVL_LSB = 8;
   localparam logic [15:0] CTL1_WMASK = 16'hfffe;
   localparam logic [15:0] CTL2_WMASK = 16'h801f;
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [3:0] TRAP_LVL_BASE = 4'h8;
endpackage

// ==== verilog/priority_resolver.sv ====
// Picks the highest-priority pending source, lowest number on a tie
`timescale 1ns/100ps
module priority_resolver (
   // Candidates
   input intc_pkg::src_vec_t pending_in,
   input intc_pkg::prio_arr_t prio_in,
   // Winner
   output logic best_valid_out,
   output logic [6:0] best_idx_out,
   output logic [2:0] best_lvl_out
);
   import intc_pkg::*;
   // Strict compare keeps the earliest source among equals
   always_comb begin
      best_valid_out = 1'b0;
      best_idx_out = 7'h00;
      best_lvl_out = 3'h0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (pending_in[i] && (!best_valid_out || prio_in[i] > best_lvl_out)) begin
            best_valid_out = 1'b1;
            best_idx_out = 7'(i);
            best_lvl_out = prio_in[i];
         end
      end
   end
endmodule

// ==== verilog/reg_if.sv ====
// Register access path between the bus slave and the controller core
`timescale 1ns/100ps
interface reg_if;
   logic wr_en;
   logic [5:0] wr_idx;
   logic [15:0] wr_data;
   logic [1:0] wr_strb;
   logic [5:0] rd_idx;
   logic [15:0] rd_data;
   modport bus (output wr_en, output wr_idx, output wr_data, output wr_strb, output rd_idx, input rd_data);
   modport regs (input wr_en, input wr_idx, input wr_data, input wr_strb, input rd_idx, output rd_data);
endinterface

// ==== verilog/vectored_priority_interrupt_controller.sv ====
// Vectored interrupt and trap controller with AXI4-Lite registers
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module vectored_priority_interrupt_controller (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // AXI4-Lite register bus
   input wire logic [7:0] s_awaddr_in,
   input wire logic s_awvalid_in,
   output logic s_awready_out,
   input wire logic [31:0] s_wdata_in,
   input wire logic [3:0] s_wstrb_in,
   input wire logic s_wvalid_in,
   output logic s_wready_out,
   output logic [1:0] s_bresp_out,
   output logic s_bvalid_out,
   input wire logic s_bready_in,
   input wire logic [7:0] s_araddr_in,
   input wire logic s_arvalid_in,
   output logic s_arready_out,
   output logic [31:0] s_rdata_out,
   output logic [1:0] s_rresp_out,
   output logic s_rvalid_out,
   input wire logic s_rready_in,
   // Peripheral, pin and trap sources
   input intc_pkg::src_vec_t src_req_in,
   input wire logic [4:0] ext_pin_in,
   input wire logic [4:0] trap_in,
   // CPU core side
   input wire logic int_ack_in,
   input wire logic handler_done_in,
   input wire logic ipl_load_in,
   input wire logic [3:0] ipl_value_in,
   output logic int_req_out,
   output logic [6:0] int_vector_out,
   output logic [3:0] int_level_out,
   output logic [23:0] int_addr_out,
   output logic [3:0] cpu_priority_level_out
);
   import intc_pkg::*;

   // Byte-lane merge of a 16-bit register write
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] strb);
      return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction
   // One 16-bit word of a per-source bit vector, top bits zero
   function automatic logic [15:0] pick_word(input src_vec_t v, input logic [5:0] k);
      logic [79:0] w;
      w = {8'h00, v};
      return w[k*16 +: 16];
   endfunction
   // Four 3-bit priority fields packed into one word
   function automatic logic [15:0] prio_word(input prio_arr_t p, input logic [5:0] k);
      logic [15:0] w;
      w = 16'h0000;
      for (int j = 0; j < 4; j++) begin
         w[4*j +: 3] = p[4*k + j];
      end
      return w;
   endfunction
   // Table entry address of a vector number
   function automatic logic [23:0] vec_addr(input logic [6:0] vec, input logic alt);
      return VEC_BASE + {16'h0000, vec, 1'b0} + (alt ? ALT_OFFSET : 24'h000000);
   endfunction

   reg_if rif ();
   axil_reg_slave i_axil_reg_slave (
      .core_clk_in(core_clk_in), .reset_in(reset_in),
      .s_awaddr_in(s_awaddr_in), .s_awvalid_in(s_awvalid_in), .s_awready_out(s_awready_out),
      .s_wdata_in(s_wdata_in), .s_wstrb_in(s_wstrb_in), .s_wvalid_in(s_wvalid_in),
      .s_wready_out(s_wready_out), .s_bresp_out(s_bresp_out), .s_bvalid_out(s_bvalid_out),
      .s_bready_in(s_bready_in), .s_araddr_in(s_araddr_in), .s_arvalid_in(s_arvalid_in),
      .s_arready_out(s_arready_out), .s_rdata_out(s_rdata_out), .s_rresp_out(s_rresp_out),
      .s_rvalid_out(s_rvalid_out), .s_rready_in(s_rready_in), .rif(rif)
   );

   src_vec_t flag_r, flag_nxt, en_r, en_nxt, set_vec, pend_vec;
   prio_arr_t prio_r, prio_nxt;
   logic [15:0] ctl1_r, ctl1_nxt, ctl2_r;
   logic [2:0] ipl_lo_r;
   logic ipl_top_r, handler_active_r, ext_armed_r;
   logic [4:0] ext_prev_r;
   logic req_r;
   logic [6:0] vec_r;
   logic [3:0] lvl_r;
   logic [23:0] addr_r;
   logic best_valid;
   logic [6:0] best_idx;
   logic [2:0] best_lvl;

   // Register write selects
   wire [5:0] widx = rif.wr_idx;
   wire wr_ctl1 = rif.wr_en && widx == IDX_CTL1;
   wire wr_ctl2 = rif.wr_en && widx == IDX_CTL2;
   wire wr_sr = rif.wr_en && widx == IDX_SR && rif.wr_strb[0];
   wire [5:0] flag_k = widx - IDX_FLAG0;
   wire [5:0] en_k = widx - IDX_EN0;
   wire [5:0] prio_k = widx - IDX_PRIO0;
   wire wr_flag = rif.wr_en && widx >= IDX_FLAG0 && widx < IDX_EN0;
   wire wr_en_reg = rif.wr_en && widx >= IDX_EN0 && widx < IDX_PRIO0;
   wire wr_prio = rif.wr_en && widx >= IDX_PRIO0 && widx < IDX_VLS;
   wire nest_dis = ctl1_r[NEST_BIT];
   wire alt_sel = ctl2_r[ALT_BIT];
   wire [4:0] edge_pol = ctl2_r[4:0];
   wire [3:0] cpu_ipl = {ipl_top_r, ipl_lo_r};

   // External pin edge detection per polarity
   wire [4:0] ext_edge = ext_armed_r ? (edge_pol & ext_prev_r & ~ext_pin_in) | (~edge_pol & ~ext_prev_r & ext_pin_in)
                                     : 5'h00;

   // Hardware set vector for the request flags
   always_comb begin
      set_vec = src_req_in;
      for (int e = 0; e < 5; e++) begin
         set_vec[EXT_SRC[e]] = set_vec[EXT_SRC[e]] | ext_edge[e];
      end
      set_vec = set_vec & IMPL_MASK;
   end

   // Flag and enable next values; a hardware set beats a software clear
   always_comb begin
      flag_nxt = flag_r;
      en_nxt = en_r;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (wr_flag && flag_k == 6'(i / 16) && rif.wr_strb[(i % 16) / 8]) begin
            flag_nxt[i] = rif.wr_data[i % 16];
         end
         if (wr_en_reg && en_k == 6'(i / 16) && rif.wr_strb[(i % 16) / 8]) begin
            en_nxt[i] = rif.wr_data[i % 16];
         end
      end
      flag_nxt = (flag_nxt | set_vec) & IMPL_MASK;
      en_nxt = en_nxt & IMPL_MASK;
   end

   // Priority fields, four sources to a register
   always_comb begin
      prio_nxt = prio_r;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (wr_prio && prio_k == 6'(i / 4) && rif.wr_strb[(i % 4) / 2]) begin
            prio_nxt[i] = rif.wr_data[4*(i % 4) +: 3];
         end
      end
   end

   // Control one: software fields plus sticky trap flags
   always_comb begin
      ctl1_nxt = wr_ctl1 ? (merge16(ctl1_r, rif.wr_data, rif.wr_strb) & CTL1_WMASK) : ctl1_r;
      ctl1_nxt[1] = ctl1_nxt[1] | trap_in[0];
      ctl1_nxt[3] = ctl1_nxt[3] | trap_in[1];
      ctl1_nxt[2] = ctl1_nxt[2] | trap_in[2];
      ctl1_nxt[4] = ctl1_nxt[4] | trap_in[3];
      ctl1_nxt[5] = ctl1_nxt[5] | trap_in[4];
   end

   // Lowest pending trap vector, in vector order
   wire [6:0] trap_vec = ctl1_r[1] ? 7'h01 : ctl1_r[3] ? 7'h02 : ctl1_r[2] ? 7'h03 : ctl1_r[4] ? 7'h04 : 7'h05;
   wire trap_any = |ctl1_r[5:1];

   assign pend_vec = flag_r & en_r;
   priority_resolver i_priority_resolver (
      .pending_in(pend_vec),
      .prio_in(prio_r),
      .best_valid_out(best_valid),
      .best_idx_out(best_idx),
      .best_lvl_out(best_lvl)
   );

   // Dispatch decision
   wire user_blocked = (ipl_lo_r == 3'h7) || ipl_top_r;
   wire nest_blocked = nest_dis && handler_active_r;
   wire user_ok = best_valid && ({1'b0, best_lvl} > cpu_ipl) && !user_blocked && !nest_blocked;
   wire trap_ok = trap_any && !ipl_top_r && !nest_blocked;
   wire [6:0] vec_nxt = trap_ok ? trap_vec : best_idx + VEC_USER_OFS;
   wire [3:0] lvl_nxt = trap_ok ? TRAP_LVL_BASE + trap_vec[3:0] : {1'b0, best_lvl};
   wire take_nxt = trap_ok || user_ok;

   // Source state registers
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         flag_r <= '0;
         en_r <= '0;
         prio_r <= '0;
         ctl1_r <= REG_RST;
         ctl2_r <= REG_RST;
      end else begin
         flag_r <= flag_nxt;
         en_r <= en_nxt;
         prio_r <= prio_nxt;
         ctl1_r <= ctl1_nxt;
         if (wr_ctl2) ctl2_r <= merge16(ctl2_r, rif.wr_data, rif.wr_strb) & CTL2_WMASK;
      end
   end

   // CPU priority level and handler tracking
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         ipl_lo_r <= 3'h0;
         ipl_top_r <= 1'b0;
         handler_active_r <= 1'b0;
      end else begin
         if (ipl_load_in) begin
            ipl_lo_r <= ipl_value_in[2:0];
            ipl_top_r <= ipl_value_in[3];
         end else if (wr_sr && !nest_dis) begin
            ipl_lo_r <= rif.wr_data[IPL_LSB +: 3];
         end
         handler_active_r <= int_ack_in || (handler_active_r && !handler_done_in);
      end
   end

   // Pin history, armed one cycle after reset to avoid a false edge
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         ext_prev_r <= 5'h00;
         ext_armed_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_pin_in;
         ext_armed_r <= 1'b1;
      end
   end

   // Latched vector, level and table address
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         req_r <= 1'b0;
         vec_r <= 7'h00;
         lvl_r <= 4'h0;
         addr_r <= VEC_BASE;
      end else begin
         req_r <= take_nxt && !int_ack_in;
         if (take_nxt) begin
            vec_r <= vec_nxt;
            lvl_r <= lvl_nxt;
            addr_r <= vec_addr(vec_nxt, alt_sel);
         end
      end
   end

   assign int_req_out = req_r;
   assign int_vector_out = vec_r;
   assign int_level_out = lvl_r;
   assign int_addr_out = addr_r;
   assign cpu_priority_level_out = cpu_ipl;

   // Register read map
   wire [5:0] ridx = rif.rd_idx;
   wire [15:0] vls_word = {4'h0, lvl_r, 1'b0, vec_r};
   assign rif.rd_data = (ridx == IDX_CTL1) ? ctl1_r :
                        (ridx == IDX_CTL2) ? ctl2_r :
                        (ridx >= IDX_FLAG0 && ridx < IDX_EN0) ? pick_word(flag_r, ridx - IDX_FLAG0) :
                        (ridx >= IDX_EN0 && ridx < IDX_PRIO0) ? pick_word(en_r, ridx - IDX_EN0) :
                        (ridx >= IDX_PRIO0 && ridx < IDX_VLS) ? prio_word(prio_r, ridx - IDX_PRIO0) :
                        (ridx == IDX_VLS) ? vls_word :
                        (ridx == IDX_SR) ? {8'h00, ipl_lo_r, 5'h00} :
                        (ridx == IDX_CORE) ? {12'h000, ipl_top_r, 3'h0} : 16'h0000;

   // Checks
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);

   a_table_addr: assert property (take_nxt |=>
      int_addr_out == 24'h000004 + {16'h0000, int_vector_out, 1'b0} + ($past(alt_sel) ? 24'h000100 : 24'h000000))
      else $error("vector address off table");
   a_user_vec_range: assert property (int_req_out && int_vector_out >= 7'h08 |->
      int_vector_out <= 7'h4f && int_vector_out != 7'h43 && int_vector_out != 7'h44)
      else $error("reserved or absent vector dispatched");
   a_trap_vec_range: assert property (int_req_out && int_vector_out < 7'h08 |->
      int_vector_out >= 7'h01 && int_vector_out <= 7'h05)
      else $error("reserved trap vector dispatched");
   a_flag_sticky: assert property (1'b1 |=> ((flag_r & $past(set_vec)) == $past(set_vec)))
      else $error("flag set lost");
   a_flag_hold: assert property (!wr_flag |=> ((flag_r & $past(flag_r)) == $past(flag_r)))
      else $error("flag cleared without software");
   a_enable_gate: assert property (best_valid |-> en_r[best_idx] && flag_r[best_idx])
      else $error("disabled source selected");
   a_level_above: assert property (take_nxt && !trap_ok |=> int_level_out > $past(cpu_ipl))
      else $error("request not above cpu level");
   a_block_ipl: assert property (user_blocked |=> !int_req_out || int_vector_out < 7'h08)
      else $error("user request while blocked");
   a_nest_block: assert property (nest_blocked |=> !int_req_out)
      else $error("preempted handler with nesting off");
   a_ipl_frozen: assert property (nest_dis && !ipl_load_in |=> $stable(ipl_lo_r))
      else $error("priority bits changed while nesting off");
   a_top_readonly: assert property (!ipl_load_in |=> $stable(ipl_top_r))
      else $error("top priority bit changed by software");
   a_fall_edge: assert property (ext_armed_r && edge_pol[0] && ext_prev_r[0] && !ext_pin_in[0] |=> flag_r[0])
      else $error("falling edge missed");
   a_unimpl_zero: assert property (!flag_r[59] && !flag_r[60] && !en_r[59])
      else $error("unimplemented source active");

   c_trap_req: cover property (int_req_out && int_vector_out == 7'h02);
   c_alt_req: cover property (int_req_out && int_addr_out[8]);
   c_nested: cover property (handler_active_r && !nest_dis && int_req_out);
   c_tie: cover property (pend_vec[3] && pend_vec[5] && prio_r[3] == prio_r[5] && best_idx == 7'h03);
endmodule
